// ### design/tcc_pkg.sv
package tcc_pkg;

  // register byte addresses
  localparam logic [15:0] TIMER61_MODE_CONTROL_ADDR  = 16'hff41;
  localparam logic [15:0] TIMER60_MODE_CONTROL_ADDR  = 16'hff4e;
  localparam logic [15:0] CARRIER_OUTPUT_CONTROL_ADDR = 16'hff4f;

  // reset values
  localparam logic [7:0] TMC_RESET = 8'h00;
  localparam logic [7:0] TCA_RESET = 8'h00;
  localparam logic [7:0] RD_IDLE   = 8'h00;

  // writable bits, fixed-zero bits drop out
  localparam logic [7:0] TMC_WR_MASK = 8'hbf;

  // mode control field positions
  localparam int unsigned RUN_BIT     = 7;
  localparam int unsigned CLK_SEL_HI  = 5;
  localparam int unsigned CLK_SEL_LO  = 3;
  localparam int unsigned MODE_HI_BIT = 2;
  localparam int unsigned MODE_LO_BIT = 1;
  localparam int unsigned OUT_EN_BIT  = 0;

  // carrier output control field positions
  localparam int unsigned REMOTE_BIT   = 2;
  localparam int unsigned NEXT_BUF_BIT = 1;
  localparam int unsigned OUT_DATA_BIT = 0;

  // count clock select codes
  localparam logic [2:0] SEL_MAIN      = 3'h0;
  localparam logic [2:0] SEL_MAIN_DIV  = 3'h1;
  localparam logic [2:0] SEL_EXT       = 3'h2;
  localparam logic [2:0] SEL_EXT_DIV2  = 3'h3;
  localparam logic [2:0] SEL_EXT_DIV4  = 3'h4;
  localparam logic [2:0] SEL_EXT_DIV8  = 3'h5;

  // external divider masks
  localparam logic [2:0] EXT_MASK_DIV2 = 3'h1;
  localparam logic [2:0] EXT_MASK_DIV4 = 3'h3;
  localparam logic [2:0] EXT_MASK_DIV8 = 3'h7;

  // main clock prescaler terminal counts
  localparam logic [3:0] PRE_DIV4_TC  = 4'h3;
  localparam logic [3:0] PRE_DIV16_TC = 4'hf;
  localparam logic [3:0] PRE_MASK4    = 4'h3;
  localparam logic [3:0] PRE_STEP     = 4'h1;

  // timer 60 operating modes
  typedef enum logic [2:0] {
    MODE_STANDALONE = 3'b000,
    MODE_CASCADE    = 3'b001,
    MODE_CARRIER    = 3'b010,
    MODE_PPG        = 3'b011,
    MODE_ILLEGAL    = 3'b100
  } tcc_mode_t;

  // timer 61 operating modes
  typedef enum logic [1:0] {
    T61_STANDALONE = 2'b00,
    T61_PATTERN    = 2'b01,
    T61_ILLEGAL    = 2'b10
  } tcc_t61_mode_t;

endpackage : tcc_pkg

// ### design/tcc_clk_sel.sv
`timescale 1ns/1ps
`default_nettype none
module tcc_clk_sel
  import tcc_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // control
  input  wire logic       run,
  input  wire logic [2:0] sel,
  // tick sources
  input  wire logic       main_div_tick,
  input  wire logic       ext_rise,
  // count tick
  output logic            tick_ff
);

  logic [2:0] ext_cnt_ff;
  logic [2:0] nxt_ext_cnt;
  logic       nxt_tick;

  // external edge divider and tick select; prohibited codes give no tick
  always_comb begin
    nxt_ext_cnt = ext_cnt_ff;
    nxt_tick    = 1'b0;
    if (!run) begin
      nxt_ext_cnt = 3'h0;
    end else begin
      if (ext_rise) begin
        nxt_ext_cnt = ext_cnt_ff + 3'h1;
      end
      unique case (sel)
        SEL_MAIN:     nxt_tick = 1'b1;
        SEL_MAIN_DIV: nxt_tick = main_div_tick;
        SEL_EXT:      nxt_tick = ext_rise;
        SEL_EXT_DIV2: nxt_tick = ext_rise && ((ext_cnt_ff & EXT_MASK_DIV2) == EXT_MASK_DIV2);
        SEL_EXT_DIV4: nxt_tick = ext_rise && ((ext_cnt_ff & EXT_MASK_DIV4) == EXT_MASK_DIV4);
        SEL_EXT_DIV8: nxt_tick = ext_rise && ((ext_cnt_ff & EXT_MASK_DIV8) == EXT_MASK_DIV8);
        default:      nxt_tick = 1'b0;
      endcase
    end
  end

  // register stage
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ext_cnt_ff <= 3'h0;
      tick_ff    <= 1'b0;
    end else begin
      ext_cnt_ff <= nxt_ext_cnt;
      tick_ff    <= nxt_tick;
    end
  end

endmodule : tcc_clk_sel
`default_nettype wire

// ### design/tcc_top.sv
// Overview of operation
// [R1] clearing timer 60 run clears and stops it, and timer 50 in cascade
// [R2] setting timer 60 run starts it, and timer 50 in cascade
// [R3] in cascade the timer 50 run bit is ignored
// [R4] timer 60 clock: main, main/4, external, external/2, /4, /8; rest none
// [R5] timer 60 mode decoded from both timers' mode bits, others prohibited
// [R6] mode comes from both mode registers jointly
// [R7] software stops timer 60 before changing mode or clock
// [R8] output pin low, carrier pulse, or high per data and remote bits
// [R9] data bit zero stops carrier clock and holds output low
// [R10] buffer bit copied into data bit on each timer 50 match
// [R11] software presets data bit and buffer before counting
// [R12] with output disabled software uses byte writes only
// [R13] with output enabled writes to data bit are ignored
// [R14] write while timer 50 interrupt high moves buffer into data bit
// [R15] software waits half a timer 50 clock before rewriting
// [R16] timer 61 run bit clears and stops, or starts, its counter
// [R17] timer 61 clock: main, main/16, external, external/2, /4, /8
// [R18] timer 61 mode 00 stand-alone, 10 pattern; bit 0 enables output
// [R19] 24-bit event counting uses timer 61 stand-alone with external clock
// [R20] software stops timer 61 before changing mode or clock
// [R21] carrier and PPG counters clear on either match, overflow or stop
// [R22] fixed-zero bits read zero and ignore writes
`timescale 1ns/1ps
`default_nettype none
module tcc_top
  import tcc_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // register access
  input  wire logic [15:0] bus_addr,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  input  wire logic [7:0]  bus_wdata,
  output logic      [7:0]  bus_rdata_ff,
  // timer 50 companion
  input  wire logic        t50_mode_hi,
  input  wire logic        t50_mode_lo,
  input  wire logic        t50_run,
  input  wire logic        t50_match_irq,
  output logic             t50_run_eff_ff,
  output logic             t50_cnt_clr_ff,
  // timer 60 counter events
  input  wire logic        t60_cmp_match,
  input  wire logic        t60_hcmp_match,
  input  wire logic        t60_ovf,
  input  wire logic        carrier_pulse,
  output logic             t60_cnt_tick_ff,
  output logic             t60_cnt_clr_ff,
  output tcc_mode_t        t60_mode_ff,
  output logic             carrier_clk_en_ff,
  output logic             t60_out_pin_ff,
  // timer 61 counter events
  input  wire logic        t61_cmp_match,
  input  wire logic        t61_hcmp_match,
  input  wire logic        t61_ovf,
  output logic             t61_cnt_tick_ff,
  output logic             t61_cnt_clr_ff,
  output tcc_t61_mode_t    t61_mode_ff,
  output logic             t61_out_en_ff,
  // external count input pin
  input  wire logic        ext_count_in
);

  logic [7:0]    timer60_mode_control_ff, timer61_mode_control_ff, nxt_timer60_mode_control, nxt_timer61_mode_control;
  logic          remote_level_sel_ff, next_out_data_buf_ff, out_data_bit_ff;
  logic          nxt_remote, nxt_buf, nxt_out_data;
  logic [7:0]    nxt_rdata;
  logic          wr60, wr61, wr_tca, irq_prev_ff, match_rise;
  logic          ext_s1_ff, ext_s2_ff, ext_s3_ff, ext_lvl_ff, ext_rise_ff;
  logic          nxt_ext_lvl, nxt_ext_rise;
  logic [3:0]    pre_ff, nxt_pre;
  logic          div4_ff, div16_ff, nxt_div4, nxt_div16;
  tcc_mode_t     mode_c;
  tcc_t61_mode_t mode61_c;
  logic          t60_run, t61_run, t60_out_en, cascade, t60_clr_mode, t61_clr_mode;
  logic          nxt_t50_run_eff, nxt_t50_clr, nxt_t60_clr, nxt_t61_clr, nxt_pin, nxt_clk_en;

  // field views
  assign t60_run    = timer60_mode_control_ff[RUN_BIT];
  assign t61_run    = timer61_mode_control_ff[RUN_BIT];
  assign t60_out_en = timer60_mode_control_ff[OUT_EN_BIT];
  assign wr60       = bus_wr && (bus_addr == TIMER60_MODE_CONTROL_ADDR);
  assign wr61       = bus_wr && (bus_addr == TIMER61_MODE_CONTROL_ADDR);
  assign wr_tca     = bus_wr && (bus_addr == CARRIER_OUTPUT_CONTROL_ADDR);
  assign match_rise = t50_match_irq && !irq_prev_ff;

  // joint mode decode from both timers
  always_comb begin
    mode_c = MODE_ILLEGAL;
    if (!t50_mode_lo && (timer60_mode_control_ff[MODE_HI_BIT:MODE_LO_BIT] == 2'b00)) begin
      mode_c = MODE_STANDALONE;                                   // see [R5] see [R6]
    end else if ({t50_mode_hi, t50_mode_lo, timer60_mode_control_ff[MODE_HI_BIT:MODE_LO_BIT]} == 4'b0101) begin
      mode_c = MODE_CASCADE;
    end else if ({t50_mode_hi, t50_mode_lo, timer60_mode_control_ff[MODE_HI_BIT:MODE_LO_BIT]} == 4'b0011) begin
      mode_c = MODE_CARRIER;
    end else if (!t50_mode_lo && (timer60_mode_control_ff[MODE_HI_BIT:MODE_LO_BIT] == 2'b10)) begin
      mode_c = MODE_PPG;
    end
    unique case (timer61_mode_control_ff[MODE_HI_BIT:MODE_LO_BIT])
      2'b00:   mode61_c = T61_STANDALONE;                         // see [R18]
      2'b10:   mode61_c = T61_PATTERN;
      default: mode61_c = T61_ILLEGAL;
    endcase
  end

  assign cascade      = (mode_c == MODE_CASCADE);
  assign t60_clr_mode = (mode_c == MODE_CARRIER) || (mode_c == MODE_PPG);
  assign t61_clr_mode = (mode61_c == T61_PATTERN);

  // register writes and carrier data handling
  always_comb begin
    nxt_timer60_mode_control    = timer60_mode_control_ff;
    nxt_timer61_mode_control    = timer61_mode_control_ff;
    nxt_remote   = remote_level_sel_ff;
    nxt_buf      = next_out_data_buf_ff;
    nxt_out_data = out_data_bit_ff;
    if (wr60) begin
      nxt_timer60_mode_control = bus_wdata & TMC_WR_MASK;                        // see [R22]
    end
    if (wr61) begin
      nxt_timer61_mode_control = bus_wdata & TMC_WR_MASK;
    end
    if (match_rise) begin
      nxt_out_data = next_out_data_buf_ff;                        // see [R10]
    end
    if (wr_tca) begin
      nxt_remote = bus_wdata[REMOTE_BIT];
      nxt_buf    = bus_wdata[NEXT_BUF_BIT];
      if (t50_match_irq) begin
        nxt_out_data = bus_wdata[NEXT_BUF_BIT];                   // see [R14]
      end else if (!t60_out_en) begin
        nxt_out_data = bus_wdata[OUT_DATA_BIT];                   // see [R13]
      end
    end
  end

  // registers
  always_ff @(posedge clk) begin
    if (!rstn) begin
      timer60_mode_control_ff             <= TMC_RESET;
      timer61_mode_control_ff             <= TMC_RESET;
      remote_level_sel_ff  <= TCA_RESET[REMOTE_BIT];
      next_out_data_buf_ff <= TCA_RESET[NEXT_BUF_BIT];
      out_data_bit_ff      <= TCA_RESET[OUT_DATA_BIT];
      irq_prev_ff          <= 1'b0;
    end else begin
      timer60_mode_control_ff             <= nxt_timer60_mode_control;
      timer61_mode_control_ff             <= nxt_timer61_mode_control;
      remote_level_sel_ff  <= nxt_remote;
      next_out_data_buf_ff <= nxt_buf;
      out_data_bit_ff      <= nxt_out_data;
      irq_prev_ff          <= t50_match_irq;
    end
  end

  // read mux; data bit is write-only
  always_comb begin
    nxt_rdata = RD_IDLE;
    if (bus_rd) begin
      unique case (bus_addr)
        TIMER60_MODE_CONTROL_ADDR:   nxt_rdata = timer60_mode_control_ff;
        TIMER61_MODE_CONTROL_ADDR:   nxt_rdata = timer61_mode_control_ff;
        CARRIER_OUTPUT_CONTROL_ADDR: begin
          nxt_rdata               = RD_IDLE;
          nxt_rdata[REMOTE_BIT]   = remote_level_sel_ff;
          nxt_rdata[NEXT_BUF_BIT] = next_out_data_buf_ff;
        end
        default:                     nxt_rdata = RD_IDLE;
      endcase
    end
  end

  // external input filter and main clock prescaler
  always_comb begin
    nxt_ext_lvl  = (ext_s2_ff == ext_s3_ff) ? ext_s3_ff : ext_lvl_ff;
    nxt_ext_rise = nxt_ext_lvl && !ext_lvl_ff;
    nxt_pre      = pre_ff + PRE_STEP;
    nxt_div4     = ((pre_ff & PRE_MASK4) == PRE_DIV4_TC);
    nxt_div16    = (pre_ff == PRE_DIV16_TC);
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      ext_s1_ff   <= 1'b0;
      ext_s2_ff   <= 1'b0;
      ext_s3_ff   <= 1'b0;
      ext_lvl_ff  <= 1'b0;
      ext_rise_ff <= 1'b0;
      pre_ff      <= 4'h0;
      div4_ff     <= 1'b0;
      div16_ff    <= 1'b0;
    end else begin
      ext_s1_ff   <= ext_count_in;
      ext_s2_ff   <= ext_s1_ff;
      ext_s3_ff   <= ext_s2_ff;
      ext_lvl_ff  <= nxt_ext_lvl;
      ext_rise_ff <= nxt_ext_rise;
      pre_ff      <= nxt_pre;
      div4_ff     <= nxt_div4;
      div16_ff    <= nxt_div16;
    end
  end

  // count clock selectors
  tcc_clk_sel u_sel60 (
    .clk           (clk),
    .rstn          (rstn),
    .run           (t60_run),                                     // see [R2]
    .sel           (timer60_mode_control_ff[CLK_SEL_HI:CLK_SEL_LO]),             // see [R4]
    .main_div_tick (div4_ff),
    .ext_rise      (ext_rise_ff),
    .tick_ff       (t60_cnt_tick_ff)
  );

  tcc_clk_sel u_sel61 (
    .clk           (clk),
    .rstn          (rstn),
    .run           (t61_run),                                     // see [R16]
    .sel           (timer61_mode_control_ff[CLK_SEL_HI:CLK_SEL_LO]),             // see [R17]
    .main_div_tick (div16_ff),
    .ext_rise      (ext_rise_ff),
    .tick_ff       (t61_cnt_tick_ff)
  );

  // counter control and output pin
  always_comb begin
    nxt_t50_run_eff = cascade ? t60_run : t50_run;                // see [R3]
    nxt_t50_clr     = cascade && !t60_run;                        // see [R1]
    nxt_t60_clr     = !t60_run ||                                 // see [R1]
                      (t60_clr_mode && (t60_cmp_match || t60_hcmp_match || t60_ovf)); // see [R21]
    nxt_t61_clr     = !t61_run ||                                 // see [R16]
                      (t61_clr_mode && (t61_cmp_match || t61_hcmp_match || t61_ovf)); // see [R21]
    nxt_clk_en      = out_data_bit_ff;                            // see [R9]
    nxt_pin         = t60_out_en && out_data_bit_ff &&
                      (remote_level_sel_ff || carrier_pulse);     // see [R8]
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      bus_rdata_ff      <= RD_IDLE;
      t50_run_eff_ff    <= 1'b0;
      t50_cnt_clr_ff    <= 1'b0;
      t60_cnt_clr_ff    <= 1'b1;
      t61_cnt_clr_ff    <= 1'b1;
      t60_mode_ff       <= MODE_STANDALONE;
      t61_mode_ff       <= T61_STANDALONE;
      t61_out_en_ff     <= 1'b0;
      carrier_clk_en_ff <= 1'b0;
      t60_out_pin_ff    <= 1'b0;
    end else begin
      bus_rdata_ff      <= nxt_rdata;
      t50_run_eff_ff    <= nxt_t50_run_eff;
      t50_cnt_clr_ff    <= nxt_t50_clr;
      t60_cnt_clr_ff    <= nxt_t60_clr;
      t61_cnt_clr_ff    <= nxt_t61_clr;
      t60_mode_ff       <= mode_c;
      t61_mode_ff       <= mode61_c;
      t61_out_en_ff     <= timer61_mode_control_ff[OUT_EN_BIT];                  // see [R18]
      carrier_clk_en_ff <= nxt_clk_en;
      t60_out_pin_ff    <= nxt_pin;
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence run60_rise_s;
    $rose(t60_run) && (timer60_mode_control_ff[CLK_SEL_HI:CLK_SEL_LO] == SEL_MAIN);
  endsequence
  sequence tick_next_s;
    ##1 t60_cnt_tick_ff;
  endsequence

  cascade_clear_a: assert property (cascade && !t60_run |=> // see [R1]
    t50_cnt_clr_ff && t60_cnt_clr_ff) else $error("cascade stop left a counter running");
  run_start_a: assert property (run60_rise_s |-> tick_next_s) // see [R2]
    else $error("timer 60 did not start counting");
  cascade_run_a: assert property (cascade |=> t50_run_eff_ff == $past(t60_run)) // see [R3]
    else $error("timer 50 run not governed by timer 60");
  bad_clk_sel_a: assert property (timer60_mode_control_ff[CLK_SEL_HI:CLK_SEL_LO] > SEL_EXT_DIV8 |=> // see [R4]
    !t60_cnt_tick_ff) else $error("prohibited clock code produced a tick");
  mode_carrier_a: assert property ({t50_mode_hi, t50_mode_lo} == 2'b00 && // see [R5]
    timer60_mode_control_ff[MODE_HI_BIT:MODE_LO_BIT] == 2'b11 |=> t60_mode_ff == MODE_CARRIER)
    else $error("carrier mode not decoded");
  pin_low_a: assert property (!out_data_bit_ff |=> // see [R9]
    !t60_out_pin_ff && !carrier_clk_en_ff) else $error("output not low with data bit clear");
  match_reload_a: assert property ($rose(t50_match_irq) && !wr_tca |=> // see [R10]
    out_data_bit_ff == $past(next_out_data_buf_ff)) else $error("buffer not reloaded on match");
  write_ignored_a: assert property (wr_tca && t60_out_en && !t50_match_irq |=> // see [R13]
    $stable(out_data_bit_ff)) else $error("data bit written while output enabled");
  irq_transfer_a: assert property (wr_tca && t50_match_irq |=> // see [R14]
    out_data_bit_ff == $past(bus_wdata[NEXT_BUF_BIT])) else $error("no buffer transfer");
  t61_stop_a: assert property (!t61_run |=> t61_cnt_clr_ff && !t61_cnt_tick_ff) // see [R16]
    else $error("timer 61 not cleared when stopped");
  match_clear_a: assert property (t60_clr_mode && t60_hcmp_match |=> t60_cnt_clr_ff) // see [R21]
    else $error("timer 60 not cleared on compare match");

endmodule : tcc_top
`default_nettype wire

// ### test/tcc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tcc_top_tb
  import tcc_pkg::*;
;
  // design stimulus and observation
  logic          clk, rstn, bus_wr, bus_rd, ext_count_in;
  logic [15:0]   bus_addr;
  logic [7:0]    bus_wdata, bus_rdata_ff;
  logic          t50_mode_hi, t50_mode_lo, t50_run, t50_match_irq, t50_run_eff_ff, t50_cnt_clr_ff;
  logic          t60_cmp_match, t60_hcmp_match, t60_ovf, carrier_pulse;
  logic          t60_cnt_tick_ff, t60_cnt_clr_ff, carrier_clk_en_ff, t60_out_pin_ff;
  logic          t61_cmp_match, t61_hcmp_match, t61_ovf, t61_cnt_tick_ff, t61_cnt_clr_ff;
  logic          t61_out_en_ff;
  tcc_mode_t     t60_mode_ff;
  tcc_t61_mode_t t61_mode_ff;
  int            fails, checked;

  tcc_top dut (
    .clk(clk), .rstn(rstn), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_wdata(bus_wdata), .bus_rdata_ff(bus_rdata_ff), .t50_mode_hi(t50_mode_hi),
    .t50_mode_lo(t50_mode_lo), .t50_run(t50_run), .t50_match_irq(t50_match_irq),
    .t50_run_eff_ff(t50_run_eff_ff), .t50_cnt_clr_ff(t50_cnt_clr_ff),
    .t60_cmp_match(t60_cmp_match), .t60_hcmp_match(t60_hcmp_match), .t60_ovf(t60_ovf),
    .carrier_pulse(carrier_pulse), .t60_cnt_tick_ff(t60_cnt_tick_ff),
    .t60_cnt_clr_ff(t60_cnt_clr_ff), .t60_mode_ff(t60_mode_ff),
    .carrier_clk_en_ff(carrier_clk_en_ff), .t60_out_pin_ff(t60_out_pin_ff),
    .t61_cmp_match(t61_cmp_match), .t61_hcmp_match(t61_hcmp_match), .t61_ovf(t61_ovf),
    .t61_cnt_tick_ff(t61_cnt_tick_ff), .t61_cnt_clr_ff(t61_cnt_clr_ff),
    .t61_mode_ff(t61_mode_ff), .t61_out_en_ff(t61_out_en_ff), .ext_count_in(ext_count_in)
  );

  // 50 mhz clock
  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end

  // verdict and end of run
  task automatic complete_run();
    if (fails == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : complete_run

  // compare one value
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // wait n edges, then settle
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  // one register write
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_addr  <= a;
    bus_wdata <= d;
    bus_wr    <= 1'h1;
    @(posedge clk);
    bus_wr    <= 1'h0;
  endtask : wr

  // one register read, data taken the cycle after the strobe
  task automatic chk_rd(input logic [15:0] a, input logic [7:0] exp, input string name);
    @(posedge clk);
    bus_addr <= a;
    bus_rd   <= 1'h1;
    @(posedge clk);
    bus_rd   <= 1'h0;
    #1;
    chk(name, bus_rdata_ff, exp);
  endtask : chk_rd

  // reset state and fixed-zero bits
  task automatic t_regs();
    chk("t60 clr", {7'h00, t60_cnt_clr_ff}, 8'h01);
    chk("t61 clr", {7'h00, t61_cnt_clr_ff}, 8'h01);
    chk("pin rst", {7'h00, t60_out_pin_ff}, 8'h00);
    chk_rd(TIMER61_MODE_CONTROL_ADDR, 8'h00, "timer61_mode_control rst");
    chk_rd(CARRIER_OUTPUT_CONTROL_ADDR, 8'h00, "tca rst");
    wr(TIMER61_MODE_CONTROL_ADDR, 8'hff);
    chk_rd(TIMER61_MODE_CONTROL_ADDR, 8'hbf, "timer61_mode_control rb");
    wr(TIMER60_MODE_CONTROL_ADDR, 8'h7f);
    chk_rd(TIMER60_MODE_CONTROL_ADDR, 8'h3f, "timer60_mode_control rb");
    wr(CARRIER_OUTPUT_CONTROL_ADDR, 8'hff);
    chk_rd(CARRIER_OUTPUT_CONTROL_ADDR, 8'h06, "tca rb");
    chk_rd(16'hff40, 8'h00, "unmapped");
    wr(TIMER61_MODE_CONTROL_ADDR, 8'h00);
    wr(TIMER60_MODE_CONTROL_ADDR, 8'h00);
    wr(CARRIER_OUTPUT_CONTROL_ADDR, 8'h00);
  endtask : t_regs

  // every combination of both timers' mode bits
  task automatic t_modes();
    logic [3:0] m;
    tcc_mode_t  e;
    for (int i = 0; i < 16; i++) begin
      m = i[3:0];
      if (!m[2] && m[1:0] == 2'h0) e = MODE_STANDALONE;
      else if (m == 4'h5) e = MODE_CASCADE;
      else if (m == 4'h3) e = MODE_CARRIER;
      else if (!m[2] && m[1:0] == 2'h2) e = MODE_PPG;
      else e = MODE_ILLEGAL;
      @(posedge clk);
      t50_mode_hi <= m[3];
      t50_mode_lo <= m[2];
      wr(TIMER60_MODE_CONTROL_ADDR, {5'h00, m[1:0], 1'h0});
      cyc(2);
      chk("t60 mode", {5'h00, t60_mode_ff}, {5'h00, e});
    end
  endtask : t_modes

  // cascade start and stop under the timer 60 run bit
  task automatic t_cascade();
    @(posedge clk);
    t50_mode_hi <= 1'h0;
    t50_mode_lo <= 1'h0;
    t50_run     <= 1'h1;
    wr(TIMER60_MODE_CONTROL_ADDR, 8'h00);
    cyc(2);
    chk("t50 run alone", {7'h00, t50_run_eff_ff}, 8'h01);
    @(posedge clk);
    t50_mode_lo <= 1'h1;
    wr(TIMER60_MODE_CONTROL_ADDR, 8'h02);
    cyc(2);
    chk("t50 run ign", {7'h00, t50_run_eff_ff}, 8'h00);
    chk("t50 clr stop", {7'h00, t50_cnt_clr_ff}, 8'h01);
    wr(TIMER60_MODE_CONTROL_ADDR, 8'h82);
    @(posedge clk);
    t50_run <= 1'h0;
    cyc(2);
    chk("t50 run casc", {7'h00, t50_run_eff_ff}, 8'h01);
    chk("t50 clr run", {7'h00, t50_cnt_clr_ff}, 8'h00);
    chk("t60 tick run", {7'h00, t60_cnt_tick_ff}, 8'h01);
    wr(TIMER60_MODE_CONTROL_ADDR, 8'h02);
    cyc(2);
    chk("t50 run stop", {7'h00, t50_run_eff_ff}, 8'h00);
    chk("t50 clr again", {7'h00, t50_cnt_clr_ff}, 8'h01);
    chk("t60 clr stop", {7'h00, t60_cnt_clr_ff}, 8'h01);
    chk("t60 tick stop", {7'h00, t60_cnt_tick_ff}, 8'h00);
    @(posedge clk);
    t50_mode_lo <= 1'h0;
  endtask : t_cascade

  // tick counts over 144 cycles for clock codes 0 to 6, 16 external rises
  task automatic t_clocks();
    logic [2:0] s;
    logic [7:0] n60, n61, e60, e61;
    for (int c = 0; c < 7; c++) begin
      s = c[2:0];
      e60 = (c == 0) ? 8'h90 : (c == 1) ? 8'h24 : (c < 6) ? 8'h10 >> (c - 2) : 8'h00;
      e61 = (c == 1) ? 8'h09 : e60;
      wr(TIMER60_MODE_CONTROL_ADDR, {2'h0, s, 3'h0});
      wr(TIMER61_MODE_CONTROL_ADDR, {2'h0, s, 3'h0});
      wr(TIMER60_MODE_CONTROL_ADDR, {2'h2, s, 3'h0});
      wr(TIMER61_MODE_CONTROL_ADDR, {2'h2, s, 3'h0});
      cyc(3);
      n60 = 8'h00;
      n61 = 8'h00;
      for (int k = 0; k < 144; k++) begin
        @(posedge clk);
        ext_count_in <= (k < 128) && (k % 8 < 4);
        #1;
        n60 = n60 + {7'h00, t60_cnt_tick_ff};
        n61 = n61 + {7'h00, t61_cnt_tick_ff};
      end
      chk("t60 ticks", n60, e60);
      chk("t61 ticks", n61, e61);
    end
    wr(TIMER60_MODE_CONTROL_ADDR, 8'h00);
    wr(TIMER61_MODE_CONTROL_ADDR, 8'h00);
  endtask : t_clocks

  // timer 61 mode codes and output enable
  task automatic t_t61mode();
    logic [1:0]    m;
    tcc_t61_mode_t e;
    for (int i = 0; i < 4; i++) begin
      m = i[1:0];
      e = (m == 2'h0) ? T61_STANDALONE : (m == 2'h2) ? T61_PATTERN : T61_ILLEGAL;
      wr(TIMER61_MODE_CONTROL_ADDR, {5'h00, m, m[0]});
      cyc(2);
      chk("t61 mode", {6'h00, t61_mode_ff}, {6'h00, e});
      chk("t61 oe", {7'h00, t61_out_en_ff}, {7'h00, m[0]});
    end
    wr(TIMER61_MODE_CONTROL_ADDR, 8'h00);
  endtask : t_t61mode

  // carrier output stage: data, buffer, remote, enable, match
  task automatic t_carrier();
    wr(TIMER60_MODE_CONTROL_ADDR, 8'h06);
    wr(CARRIER_OUTPUT_CONTROL_ADDR, 8'h03);
    cyc(3);
    chk("clk en on", {7'h00, carrier_clk_en_ff}, 8'h01);
    chk("pin disabled", {7'h00, t60_out_pin_ff}, 8'h00);
    chk_rd(CARRIER_OUTPUT_CONTROL_ADDR, 8'h02, "tca data");
    wr(TIMER60_MODE_CONTROL_ADDR, 8'h07);
    @(posedge clk);
    carrier_pulse <= 1'h1;
    cyc(3);
    chk("pin pulse hi", {7'h00, t60_out_pin_ff}, 8'h01);
    @(posedge clk);
    carrier_pulse <= 1'h0;
    cyc(3);
    chk("pin pulse lo", {7'h00, t60_out_pin_ff}, 8'h00);
    wr(CARRIER_OUTPUT_CONTROL_ADDR, 8'h04);
    cyc(3);
    chk("pin level", {7'h00, t60_out_pin_ff}, 8'h01);
    @(posedge clk);
    t50_match_irq <= 1'h1;
    cyc(3);
    chk("pin match", {7'h00, t60_out_pin_ff}, 8'h00);
    chk("clk en off", {7'h00, carrier_clk_en_ff}, 8'h00);
    wr(CARRIER_OUTPUT_CONTROL_ADDR, 8'h06);
    cyc(3);
    chk("pin wr irq", {7'h00, t60_out_pin_ff}, 8'h01);
    @(posedge clk);
    t50_match_irq <= 1'h0;
    wr(TIMER60_MODE_CONTROL_ADDR, 8'h06);
    wr(CARRIER_OUTPUT_CONTROL_ADDR, 8'h00);
  endtask : t_carrier

  // one counter event on both timers, clear pulses counted
  task automatic ev(input int e, output logic [7:0] n60, output logic [7:0] n61);
    @(posedge clk);
    t60_cmp_match  <= (e == 0);
    t60_hcmp_match <= (e == 1);
    t60_ovf        <= (e == 2);
    t61_cmp_match  <= (e == 0);
    t61_hcmp_match <= (e == 1);
    t61_ovf        <= (e == 2);
    @(posedge clk);
    {t60_cmp_match, t60_hcmp_match, t60_ovf} <= 3'h0;
    {t61_cmp_match, t61_hcmp_match, t61_ovf} <= 3'h0;
    n60 = 8'h00;
    n61 = 8'h00;
    repeat (4) begin
      #1;
      n60 = n60 + {7'h00, t60_cnt_clr_ff};
      n61 = n61 + {7'h00, t61_cnt_clr_ff};
      @(posedge clk);
    end
  endtask : ev

  // counter clearing in carrier, PPG and pattern modes, none on high match in stand-alone mode
  task automatic t_clear();
    logic [7:0] n60, n61;
    wr(TIMER61_MODE_CONTROL_ADDR, 8'h84);
    for (int p = 0; p < 2; p++) begin
      wr(TIMER60_MODE_CONTROL_ADDR, 8'h00);
      wr(TIMER60_MODE_CONTROL_ADDR, (p == 0) ? 8'h86 : 8'h84);
      for (int e = 0; e < 3; e++) begin
        ev(e, n60, n61);
        chk("t60 clr ev", n60, 8'h01);
        chk("t61 clr ev", n61, 8'h01);
      end
    end
    wr(TIMER60_MODE_CONTROL_ADDR, 8'h00);
    wr(TIMER61_MODE_CONTROL_ADDR, 8'h00);
    wr(TIMER60_MODE_CONTROL_ADDR, 8'h80);
    wr(TIMER61_MODE_CONTROL_ADDR, 8'h80);
    ev(1, n60, n61);
    chk("t60 clr alone", n60, 8'h00);
    chk("t61 clr alone", n61, 8'h00);
  endtask : t_clear

  // main sequence
  initial begin
    {rstn, bus_wr, bus_rd, ext_count_in, carrier_pulse} = 5'h00;
    {t50_mode_hi, t50_mode_lo, t50_run, t50_match_irq} = 4'h0;
    {t60_cmp_match, t60_hcmp_match, t60_ovf} = 3'h0;
    {t61_cmp_match, t61_hcmp_match, t61_ovf} = 3'h0;
    bus_addr  = 16'h0000;
    bus_wdata = 8'h00;
    fails     = 0;
    checked   = 0;
    repeat (12) @(posedge clk);
    rstn <= 1'h1;
    cyc(1);
    t_regs();
    t_modes();
    t_cascade();
    t_clocks();
    t_t61mode();
    t_carrier();
    t_clear();
    complete_run();
  end

  // hang guard
  initial begin
    #400000;
    fails++;
    complete_run();
  end
endmodule : tcc_top_tb
`default_nettype wire
